// File: bench/dpt_out_evt_assertions.sv
`timescale 1ns/10ps
module dpt_out_evt_chk (
    input wire       sys_clk_i, reset_i, ce_i, sleep_standby_i, debug_halt_i,
    input wire       run_while_halted_i, cycle_end_i, compare_a_set_i, compare_b_set_i,
    input wire       fault_ctrl_we_i, evt_a_set_o, evt_b_set_o, programmable_out_event_o,
    input wire       irq_trigger_o, timer_run_o,
    input wire [2:0] flag_clear_i, interrupt_flag_o,
    input wire [3:0] waveform_oe_o,
    input wire [7:0] fault_ctrl_o
);
    wire tick = ce_i & ~sleep_standby_i & ~(debug_halt_i & ~run_while_halted_i);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    AST_EVT_ASET: assert property (tick && compare_a_set_i |=> evt_a_set_o)
        else $error("a-set match gave no event");
    AST_EVT_BSET: assert property (evt_b_set_o |-> $past(compare_b_set_i) && $past(tick))
        else $error("b-set event without match");
    AST_PROGRAMMABLE_OUT_EVENT_ONE: assert property (programmable_out_event_o |=> !programmable_out_event_o)
        else $error("programmable event longer than one cycle");
    AST_OVF_SET: assert property (tick && cycle_end_i |-> ##1 interrupt_flag_o[0])
        else $error("cycle end did not set overflow flag");
    AST_FLAG_STAY: assert property (interrupt_flag_o[0] && !flag_clear_i[0] |=> interrupt_flag_o[0])
        else $error("overflow flag dropped without clear");
    AST_FLAG_CLEAR: assert property (ce_i && flag_clear_i[0] && !(tick && cycle_end_i)
        |=> !interrupt_flag_o[0])
        else $error("overflow flag not cleared");
    AST_IRQ_OR: assert property (irq_trigger_o |-> interrupt_flag_o[2:1] != 2'h0)
        else $error("trigger request without trigger flag");
    AST_OE_FOLLOW: assert property (tick |=> waveform_oe_o == $past(fault_ctrl_o[7:4]))
        else $error("pin enables differ from enable bits");
    AST_FC_LOCK: assert property (!fault_ctrl_we_i |=> $stable(fault_ctrl_o))
        else $error("fault control changed without write");
    AST_HALT_STOP: assert property ((debug_halt_i && !run_while_halted_i) [*2] |-> !timer_run_o)
        else $error("timer runs while halted");
    AST_STBY_STOP: assert property (sleep_standby_i |=> !timer_run_o)
        else $error("timer runs in standby");
endmodule

// File: bench/dpt_power_stage.sv
`timescale 1ns/10ps
module dpt_power_stage (
    // pin levels and drive enables from the timer
    input  wire [3:0] level_i,
    input  wire [3:0] oe_i,
    // gate inputs of the switches
    output wire [3:0] gate_o
);
    // a released pin falls to the gate driver's pull-down, switch off
    assign gate_o = oe_i & level_i;
endmodule

// File: bench/test_dpt_out_evt.sv
`timescale 1ns/10ps
module test_dpt_out_evt;
    typedef struct {int cyc; int sel; logic [7:0] exp;} dpt_note_t;
    reg sys_clk_i = 1'b0, reset_i = 1'b1, ce_i = 1'b1;
    reg wave_a_i = 1'b0, wave_b_i = 1'b0, one_ramp_i = 1'b0, cycle_end_i = 1'b0;
    reg compare_b_clear_i = 1'b0, compare_a_set_i = 1'b0, compare_b_set_i = 1'b0;
    reg compare_a_clear_i = 1'b0, sw_restart_i = 1'b0, output_override_enable_i = 1'b0;
    reg out_c_source_select_i = 1'b0, out_d_source_select_i = 1'b0;
    reg change_protection_unlock_i = 1'b0, fault_ctrl_we_i = 1'b0;
    reg sleep_standby_i = 1'b0, debug_halt_i = 1'b0, run_while_halted_i = 1'b0;
    reg debug_fault_inject_i = 1'b0;
    reg [1:0] phase_i = 2'h0, capture_done_i = 2'h0, in_event_i = 2'h0;
    reg [1:0] delay_mode_i = 2'h0, delay_prescaler_i = 2'h0;
    reg [2:0] delay_trig_sel_i = 3'h0, int_enable_i = 3'h0, flag_clear_i = 3'h0;
    reg [3:0] input_mode_a_i = 4'h0, input_mode_b_i = 4'h0;
    reg [3:0] phase_values_a_i = 4'h0, phase_values_b_i = 4'h0;
    reg [7:0] fault_ctrl_wdata_i = 8'h00, delay_value_i = 8'h00;
    wire [3:0] waveform_out_o, waveform_oe_o, gate_w;
    wire evt_b_clear_o, evt_a_set_o, evt_b_set_o, programmable_out_event_o, blank_o;
    wire [7:0] fault_ctrl_o;
    wire [2:0] interrupt_flag_o;
    wire irq_overflow_o, irq_trigger_o, timer_run_o;
    int cyc = 0, base = 0, err_count = 0, check_count = 0, k, d;
    logic [31:0] rnd;
    dpt_note_t q[$];
    dpt_note_t nt;

    dpt_out_evt dut_u (.sys_clk_i, .reset_i, .ce_i, .wave_a_i, .wave_b_i, .phase_i, .one_ramp_i,
        .cycle_end_i, .compare_b_clear_i, .compare_a_set_i, .compare_b_set_i, .compare_a_clear_i,
        .capture_done_i, .in_event_i, .input_mode_a_i, .input_mode_b_i, .sw_restart_i,
        .output_override_enable_i, .out_c_source_select_i, .out_d_source_select_i,
        .phase_values_a_i, .phase_values_b_i, .change_protection_unlock_i, .fault_ctrl_we_i,
        .fault_ctrl_wdata_i, .delay_mode_i, .delay_trig_sel_i, .delay_prescaler_i,
        .delay_value_i, .int_enable_i, .flag_clear_i, .sleep_standby_i, .debug_halt_i,
        .run_while_halted_i, .debug_fault_inject_i, .waveform_out_o, .waveform_oe_o,
        .evt_b_clear_o, .evt_a_set_o, .evt_b_set_o, .programmable_out_event_o, .blank_o,
        .cnt_jump_next_o(), .cnt_exec_opp_o(), .cnt_wait_o(), .cnt_dead_o(), .fault_ctrl_o,
        .interrupt_flag_o, .irq_overflow_o, .irq_trigger_o, .timer_run_o);
    dpt_power_stage stage_u (.level_i(waveform_out_o), .oe_i(waveform_oe_o), .gate_o(gate_w));

    always #4 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) cyc <= cyc + 1;

    task report_and_stop();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // run-away guard, the whole sequence needs well under a thousand cycles
    always @(posedge sys_clk_i) if (cyc == 3000) begin
        err_count++;
        report_and_stop();
    end

    task step();
        @(posedge sys_clk_i);
        base = cyc;
    endtask

    // expected value of one output group, due dly negedges after this edge
    task automatic note(input int dly, input int sel, input logic [7:0] exp);
        dpt_note_t n;
        int i;
        n.cyc = base + dly;
        n.sel = sel;
        n.exp = exp;
        i = q.size();
        while (i > 0 && q[i-1].cyc > n.cyc) i--;
        q.insert(i, n);
    endtask

    task check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    function automatic logic [7:0] obs(input int sel);
        case (sel)
            0: obs = {4'h0, gate_w};
            1: obs = fault_ctrl_o;
            2: obs = {5'h00, interrupt_flag_o};
            3: obs = {6'h00, irq_trigger_o, irq_overflow_o};
            4: obs = {5'h00, evt_b_clear_o, evt_a_set_o, evt_b_set_o};
            5: obs = {6'h00, blank_o, programmable_out_event_o};
            6: obs = {7'h00, timer_run_o};
            default: obs = {4'h0, waveform_oe_o};
        endcase
    endfunction

    always @(negedge sys_clk_i) begin
        while (q.size() > 0 && q[0].cyc <= cyc) begin
            nt = q.pop_front();
            check(obs(nt.sel), nt.exp);
        end
    end

    initial begin
        void'($urandom(32'hF91C5BE1));
        repeat (5) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        step();
        note(1, 1, 8'h00);
        fault_ctrl_we_i <= 1'b1;
        fault_ctrl_wdata_i <= 8'hF5;
        note(2, 1, 8'h00);
        step();
        fault_ctrl_we_i <= 1'b0;
        change_protection_unlock_i <= 1'b1;
        step();
        change_protection_unlock_i <= 1'b0;
        fault_ctrl_we_i <= 1'b1;
        note(2, 1, 8'hF5);
        note(2, 7, 8'h00);
        note(3, 7, 8'h0F);
        step();
        fault_ctrl_we_i <= 1'b0;
        $display("test protected write done");
        for (k = 0; k < 4; k++) begin
            step();
            rnd = $urandom;
            {out_d_source_select_i, out_c_source_select_i, wave_b_i, wave_a_i} <= rnd[3:0];
            note(2, 0, {4'h0, rnd[3] ? rnd[1] : rnd[0], rnd[2] ? rnd[1] : rnd[0], rnd[1:0]});
        end
        for (k = 0; k < 4; k++) begin
            step();
            rnd = $urandom;
            output_override_enable_i <= 1'b1;
            {out_d_source_select_i, out_c_source_select_i} <= 2'b01;
            phase_i <= k[1:0];
            {phase_values_b_i, phase_values_a_i} <= rnd[7:0];
            note(2, 0, {4'h0, rnd[k], rnd[4+k], rnd[4+k], rnd[k]});
        end
        step();
        rnd = $urandom;
        one_ramp_i <= 1'b1;
        phase_i <= 2'h2;
        {phase_values_b_i, phase_values_a_i} <= rnd[7:0];
        note(2, 0, {4'h0, rnd[0], rnd[6], rnd[6], rnd[0]});
        step();
        phase_i <= 2'h1;
        note(2, 0, {4'h0, rnd[1], rnd[6], rnd[6], rnd[1]});
        $display("test routing and override done");
        step();
        output_override_enable_i <= 1'b0;
        one_ramp_i <= 1'b0;
        input_mode_a_i <= 4'h4;
        in_event_i <= 2'b01;
        int_enable_i <= 3'b010;
        note(2, 0, 8'h05);
        note(2, 2, 8'h02);
        note(2, 3, 8'h02);
        step();
        in_event_i <= 2'b00;
        input_mode_a_i <= 4'h0;
        step();
        flag_clear_i <= 3'b010;
        note(2, 2, 8'h00);
        note(2, 3, 8'h00);
        step();
        flag_clear_i <= 3'b000;
        capture_done_i <= 2'b10;
        note(2, 2, 8'h04);
        note(2, 3, 8'h00);
        step();
        capture_done_i <= 2'b00;
        flag_clear_i <= 3'b100;
        step();
        flag_clear_i <= 3'b000;
        int_enable_i <= 3'b001;
        cycle_end_i <= 1'b1;
        note(2, 2, 8'h01);
        note(2, 3, 8'h01);
        step();
        cycle_end_i <= 1'b0;
        note(3, 3, 8'h01);
        step();
        step();
        flag_clear_i <= 3'b001;
        note(2, 2, 8'h00);
        note(2, 3, 8'h00);
        step();
        flag_clear_i <= 3'b000;
        $display("test faults and flags done");
        step();
        compare_b_clear_i <= 1'b1;
        note(2, 4, 8'h04);
        step();
        compare_b_clear_i <= 1'b0;
        compare_a_set_i <= 1'b1;
        note(2, 4, 8'h02);
        step();
        compare_a_set_i <= 1'b0;
        compare_b_set_i <= 1'b1;
        note(2, 4, 8'h01);
        step();
        compare_b_set_i <= 1'b0;
        note(2, 4, 8'h00);
        $display("test compare events done");
        for (k = 0; k < 4; k++) begin
            step();
            rnd = $urandom;
            delay_mode_i <= 2'h2;
            delay_trig_sel_i <= k[2:0];
            delay_prescaler_i <= rnd[4:3];
            delay_value_i <= {5'h00, rnd[2:0]};
            step();
            {compare_a_clear_i, compare_b_set_i, compare_a_set_i, compare_b_clear_i} <= 4'h1 << k;
            d = 2 + (rnd[2:0] << rnd[4:3]);
            note(d - 1, 5, 8'h00);
            note(d, 5, 8'h01);
            note(d + 1, 5, 8'h00);
            step();
            {compare_a_clear_i, compare_b_set_i, compare_a_set_i, compare_b_clear_i} <= 4'h0;
            repeat (d + 2) step();
        end
        delay_mode_i <= 2'h1;
        delay_trig_sel_i <= 3'h1;
        delay_value_i <= 8'h03;
        delay_prescaler_i <= 2'h0;
        step();
        compare_a_set_i <= 1'b1;
        note(2, 5, 8'h03);
        note(3, 5, 8'h02);
        note(7, 5, 8'h00);
        step();
        compare_a_set_i <= 1'b0;
        repeat (8) step();
        delay_mode_i <= 2'h0;
        $display("test programmable event done");
        step();
        debug_halt_i <= 1'b1;
        note(2, 6, 8'h00);
        step();
        run_while_halted_i <= 1'b1;
        note(2, 6, 8'h01);
        step();
        sleep_standby_i <= 1'b1;
        note(2, 6, 8'h00);
        step();
        sleep_standby_i <= 1'b0;
        debug_fault_inject_i <= 1'b1;
        input_mode_a_i <= 4'h4;
        input_mode_b_i <= 4'h4;
        note(3, 0, 8'h05);
        while (q.size() > 0) step();
        $display("test debug and sleep done");
        report_and_stop();
    end
endmodule

bind dpt_out_evt dpt_out_evt_chk chk_u (.sys_clk_i, .reset_i, .ce_i, .sleep_standby_i,
    .debug_halt_i, .run_while_halted_i, .cycle_end_i, .compare_a_set_i, .compare_b_set_i,
    .fault_ctrl_we_i, .evt_a_set_o, .evt_b_set_o, .programmable_out_event_o, .irq_trigger_o,
    .timer_run_o, .flag_clear_i, .interrupt_flag_o, .waveform_oe_o, .fault_ctrl_o);

// File: logic/dpt_delay.v
`timescale 1ns/10ps
`include "dpt_consts.vh"

module dpt_delay (
    // clock and reset
    input  wire       sys_clk_i,
    input  wire       reset_i,
    input  wire       tick_i,
    // configuration
    input  wire [1:0] mode_i,
    input  wire [2:0] trig_sel_i,
    input  wire [1:0] presc_i,
    input  wire [7:0] value_i,
    // trigger sources
    input  wire [5:0] src_i,
    // results
    output reg        event_o,
    output reg        blank_o
);

    localparam ST_IDLE = 2'b01;
    localparam ST_CNT  = 2'b10;

    reg  [1:0] state_r;
    reg  [7:0] remain_r;
    reg  [7:0] pre_r;
    wire [7:0] pre_max = (8'h01 << presc_i) - 8'h01;
    wire       trig    = src_i[trig_sel_i] & (trig_sel_i <= `DPT_TS_IN_B);
    wire       blank   = (mode_i == `DPT_DM_BLANK);
    wire       delayed = (mode_i == `DPT_DM_EVENT);

    always @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_r  <= ST_IDLE;
            remain_r <= 8'h00;
            pre_r    <= 8'h00;
            event_o  <= 1'b0;
            blank_o  <= 1'b0;
        end else if (tick_i) begin
            event_o <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    // blanking owns the counter: event goes out undelayed
                    if (trig && blank) begin
                        event_o <= 1'b1;
                    end
                    if (trig && (blank || delayed)) begin
                        if (value_i == 8'h00) begin
                            event_o <= delayed || blank;
                        end else begin
                            state_r  <= ST_CNT;
                            remain_r <= value_i;
                            pre_r    <= 8'h00;
                            blank_o  <= blank;
                        end
                    end
                end
                ST_CNT: begin
                    // delay clock = sync clock / prescaler
                    if (pre_r == pre_max) begin
                        pre_r <= 8'h00;
                        if (remain_r == 8'h01) begin
                            state_r <= ST_IDLE;
                            event_o <= delayed;
                            blank_o <= 1'b0;
                        end else begin
                            remain_r <= remain_r - 8'h01;
                        end
                    end else begin
                        pre_r <= pre_r + 8'h01;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

endmodule

// File: logic/dpt_out_evt.v
`timescale 1ns/10ps
`include "dpt_consts.vh"

// What this block does
// - outputs drive only while enable bit set
// - fault forces its input's outputs to fault value, all four in stop-all modes
// - outputs c and d copy a or b
// - override takes levels from per-phase fields
// - one-ramp: a, b use own phases only
// - input event forces outputs toward fault values
// - compare-match event pulses last one cycle
// - programmable event from trigger or compares
// - blanking shares trigger, event goes undelayed
// - delay counts delay-clock cycles, 0 to 255
// - delay clock is sync clock over prescaler
// - level input actions per input mode
// - edge input actions per input mode
// - cycle end sets the overflow flag
// - input events set trigger flags a, b
// - request while flag and enable set
// - two trigger requests ORed together
// - runs in idle, stops in standby
// - debug halt stops timer unless run bit
// - debug fault bit injects fault during halt, with run bit set
// - capture also sets matching trigger flag
// - fault control writes need unlock key
module dpt_out_evt (
    // clock, reset, enable
    input  wire       sys_clk_i,
    input  wire       reset_i,
    input  wire       ce_i,
    // counter core status
    input  wire       wave_a_i,
    input  wire       wave_b_i,
    input  wire [1:0] phase_i,
    input  wire       one_ramp_i,
    input  wire       cycle_end_i,
    input  wire       compare_b_clear_i,
    input  wire       compare_a_set_i,
    input  wire       compare_b_set_i,
    input  wire       compare_a_clear_i,
    input  wire [1:0] capture_done_i,
    // input events and modes
    input  wire [1:0] in_event_i,
    input  wire [3:0] input_mode_a_i,
    input  wire [3:0] input_mode_b_i,
    input  wire       sw_restart_i,
    // control c and d fields
    input  wire       output_override_enable_i,
    input  wire       out_c_source_select_i,
    input  wire       out_d_source_select_i,
    input  wire [3:0] phase_values_a_i,
    input  wire [3:0] phase_values_b_i,
    // protected fault control write
    input  wire       change_protection_unlock_i,
    input  wire       fault_ctrl_we_i,
    input  wire [7:0] fault_ctrl_wdata_i,
    // delay control
    input  wire [1:0] delay_mode_i,
    input  wire [2:0] delay_trig_sel_i,
    input  wire [1:0] delay_prescaler_i,
    input  wire [7:0] delay_value_i,
    // interrupts
    input  wire [2:0] int_enable_i,
    input  wire [2:0] flag_clear_i,
    // sleep and debug
    input  wire       sleep_standby_i,
    input  wire       debug_halt_i,
    input  wire       run_while_halted_i,
    input  wire       debug_fault_inject_i,
    // waveform pins
    output wire [3:0] waveform_out_o,
    output wire [3:0] waveform_oe_o,
    // events
    output reg        evt_b_clear_o,
    output reg        evt_a_set_o,
    output reg        evt_b_set_o,
    output wire       programmable_out_event_o,
    output wire       blank_o,
    // counter flow requests, per input channel
    output reg  [1:0] cnt_jump_next_o,
    output reg  [1:0] cnt_exec_opp_o,
    output reg  [1:0] cnt_wait_o,
    output reg  [1:0] cnt_dead_o,
    // status
    output reg  [7:0] fault_ctrl_o,
    output reg  [2:0] interrupt_flag_o,
    output reg        irq_overflow_o,
    output reg        irq_trigger_o,
    output reg        timer_run_o
);

    reg  [2:0] unlock_cnt_r;
    reg  [1:0] ev_d_r;
    reg  [1:0] latch_r;
    reg  [1:0] act_d_r;
    reg  [2:0] flag_nxt;
    reg  [3:0] forced;
    wire       run;
    wire       tick;
    wire [1:0] ev;
    wire [1:0] ev_rise;
    wire [1:0] active;
    wire [1:0] stop_all;
    wire [7:0] modes;
    wire [5:0] trig_src;

    // frozen in standby and in a debug halt unless told to keep running
    assign run  = !sleep_standby_i && !(debug_halt_i && !run_while_halted_i);
    assign tick = ce_i && run;

    // halt with fault injection looks like an event on both inputs
    assign ev      = in_event_i | {2{debug_halt_i && debug_fault_inject_i}};
    assign ev_rise = ev & ~ev_d_r;
    assign modes   = {input_mode_b_i, input_mode_a_i};

    always @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            timer_run_o <= 1'b0;
        end else if (ce_i) begin
            timer_run_o <= run;
        end
    end

    // unlock window and protected register
    always @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            unlock_cnt_r <= 3'h0;
            fault_ctrl_o <= `DPT_FC_RESET;
        end else if (ce_i) begin
            if (change_protection_unlock_i) begin
                unlock_cnt_r <= `DPT_CCP_WINDOW;
            end else if (unlock_cnt_r != 3'h0) begin
                unlock_cnt_r <= unlock_cnt_r - 3'h1;
            end
            if (fault_ctrl_we_i && unlock_cnt_r != 3'h0) begin
                fault_ctrl_o <= fault_ctrl_wdata_i;
                unlock_cnt_r <= 3'h0;
            end
        end
    end

    // per input channel fault handling
    genvar c;
    generate
        for (c = 0; c < 2; c = c + 1) begin : g_ch
            wire [3:0] m     = modes[4*c+3:4*c];
            wire       edge_m = (m == `DPT_IM_EDGE_JUMP) || (m == `DPT_IM_EDGE_FREQ);
            wire       lvl_m  = (m != `DPT_IM_NONE) && !edge_m && (m != `DPT_IM_ALL_SW)
                                && (m <= `DPT_IM_LVL_FREQ);

            // edge modes hold to cycle end, software mode until restart
            assign active[c]   = (lvl_m && ev[c]) || latch_r[c];
            assign stop_all[c] = (m >= `DPT_IM_ALL_FREQ) && (m <= `DPT_IM_ALL_SW);

            always @(posedge sys_clk_i or posedge reset_i) begin
                if (reset_i) begin
                    ev_d_r[c]          <= 1'b0;
                    latch_r[c]         <= 1'b0;
                    act_d_r[c]         <= 1'b0;
                    cnt_jump_next_o[c] <= 1'b0;
                    cnt_exec_opp_o[c]  <= 1'b0;
                    cnt_wait_o[c]      <= 1'b0;
                    cnt_dead_o[c]      <= 1'b0;
                end else if (tick) begin
                    ev_d_r[c]  <= ev[c];
                    act_d_r[c] <= active[c];
                    if (ev_rise[c] && (edge_m || m == `DPT_IM_ALL_SW)) begin
                        latch_r[c] <= 1'b1;
                    end else if ((edge_m && cycle_end_i) ||
                                 (m == `DPT_IM_ALL_SW && sw_restart_i)) begin
                        latch_r[c] <= 1'b0;
                    end else if (m == `DPT_IM_NONE) begin
                        latch_r[c] <= 1'b0;
                    end
                    cnt_jump_next_o[c] <= active[c] && !act_d_r[c] &&
                                          (m == `DPT_IM_JUMP_OPP || m == `DPT_IM_ALL_JUMP ||
                                           m == `DPT_IM_EDGE_JUMP);
                    cnt_exec_opp_o[c]  <= active[c] && (m == `DPT_IM_EXEC_OPP ||
                                                        m == `DPT_IM_EXEC_OPP_F);
                    cnt_wait_o[c]      <= active[c] && (m == `DPT_IM_JUMP_OPP ||
                                          m == `DPT_IM_EXEC_OPP || m == `DPT_IM_ALL_JUMP ||
                                          m == `DPT_IM_ALL_SW);
                    cnt_dead_o[c]      <= active[c] && (m == `DPT_IM_ALL_DEAD);
                end
            end
        end
    endgenerate

    // which pins take their fault value this cycle
    always @* begin
        forced = 4'h0;
        if (active[0]) begin
            forced[0] = 1'b1;
            forced[2] = forced[2] | !out_c_source_select_i;
            forced[3] = forced[3] | !out_d_source_select_i;
        end
        if (active[1]) begin
            forced[1] = 1'b1;
            forced[2] = forced[2] | out_c_source_select_i;
            forced[3] = forced[3] | out_d_source_select_i;
        end
        if ((active[0] && stop_all[0]) || (active[1] && stop_all[1])) begin
            forced = 4'hF;
        end
    end

    dpt_wave_mux u_mux (
        .sys_clk_i             (sys_clk_i),
        .reset_i               (reset_i),
        .tick_i                (tick),
        .wave_a_i              (wave_a_i),
        .wave_b_i              (wave_b_i),
        .phase_i               (phase_i),
        .one_ramp_i            (one_ramp_i),
        .override_i            (output_override_enable_i),
        .phase_values_a_i      (phase_values_a_i),
        .phase_values_b_i      (phase_values_b_i),
        .out_c_source_select_i (out_c_source_select_i),
        .out_d_source_select_i (out_d_source_select_i),
        .fault_ctrl_i          (fault_ctrl_o),
        .forced_i              (forced),
        .level_o               (waveform_out_o),
        .oe_o                  (waveform_oe_o)
    );

    // compare-match strobes, one cycle each
    always @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            evt_b_clear_o <= 1'b0;
            evt_a_set_o   <= 1'b0;
            evt_b_set_o   <= 1'b0;
        end else if (tick) begin
            evt_b_clear_o <= compare_b_clear_i;
            evt_a_set_o   <= compare_a_set_i;
            evt_b_set_o   <= compare_b_set_i;
        end else if (ce_i) begin
            evt_b_clear_o <= 1'b0;
            evt_a_set_o   <= 1'b0;
            evt_b_set_o   <= 1'b0;
        end
    end

    assign trig_src = {ev_rise[1], ev_rise[0], compare_a_clear_i,
                       compare_b_set_i, compare_a_set_i, compare_b_clear_i};

    dpt_delay u_delay (
        .sys_clk_i  (sys_clk_i),
        .reset_i    (reset_i),
        .tick_i     (tick),
        .mode_i     (delay_mode_i),
        .trig_sel_i (delay_trig_sel_i),
        .presc_i    (delay_prescaler_i),
        .value_i    (delay_value_i),
        .src_i      (trig_src),
        .event_o    (programmable_out_event_o),
        .blank_o    (blank_o)
    );

    // flags: bit0 cycle end, bit1 input a, bit2 input b; set beats clear
    always @* begin
        flag_nxt = interrupt_flag_o & ~flag_clear_i;
        if (tick) begin
            flag_nxt[0] = flag_nxt[0] | cycle_end_i;
            flag_nxt[1] = flag_nxt[1] | ev_rise[0] | capture_done_i[0];
            flag_nxt[2] = flag_nxt[2] | ev_rise[1] | capture_done_i[1];
        end
    end

    always @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            interrupt_flag_o <= 3'h0;
            irq_overflow_o   <= 1'b0;
            irq_trigger_o    <= 1'b0;
        end else if (ce_i) begin
            interrupt_flag_o <= flag_nxt;
            irq_overflow_o   <= flag_nxt[0] && int_enable_i[0];
            irq_trigger_o    <= |(flag_nxt[2:1] & int_enable_i[2:1]);
        end
    end

endmodule

// File: logic/dpt_wave_mux.v
`timescale 1ns/10ps
`include "dpt_consts.vh"

module dpt_wave_mux (
    // clock and reset
    input  wire       sys_clk_i,
    input  wire       reset_i,
    input  wire       tick_i,
    // native waveforms and counter phase
    input  wire       wave_a_i,
    input  wire       wave_b_i,
    input  wire [1:0] phase_i,
    input  wire       one_ramp_i,
    // configuration
    input  wire       override_i,
    input  wire [3:0] phase_values_a_i,
    input  wire [3:0] phase_values_b_i,
    input  wire       out_c_source_select_i,
    input  wire       out_d_source_select_i,
    input  wire [7:0] fault_ctrl_i,
    input  wire [3:0] forced_i,
    // pins
    output reg  [3:0] level_o,
    output reg  [3:0] oe_o
);

    reg  a_lvl;
    reg  b_lvl;
    wire [3:0] base;

    always @* begin
        a_lvl = wave_a_i;
        b_lvl = wave_b_i;
        if (override_i) begin
            a_lvl = phase_values_a_i[phase_i];
            b_lvl = phase_values_b_i[phase_i];
            // one-ramp: each output only looks at its own phases
            if (one_ramp_i && phase_i[1]) begin
                a_lvl = phase_values_a_i[`DPT_PH_DTA];
            end
            if (one_ramp_i && !phase_i[1]) begin
                b_lvl = phase_values_b_i[`DPT_PH_DTB];
            end
        end
    end

    // c and d copy a or b
    assign base = {out_d_source_select_i ? b_lvl : a_lvl,
                   out_c_source_select_i ? b_lvl : a_lvl, b_lvl, a_lvl};

    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1) begin : g_pin
            always @(posedge sys_clk_i or posedge reset_i) begin
                if (reset_i) begin
                    level_o[i] <= 1'b0;
                    oe_o[i]    <= 1'b0;
                end else if (tick_i) begin
                    // fault value wins the moment a fault is seen
                    level_o[i] <= forced_i[i] ? fault_ctrl_i[`DPT_FC_VAL_LSB + i] : base[i];
                    oe_o[i]    <= fault_ctrl_i[`DPT_FC_EN_LSB + i];
                end
            end
        end
    endgenerate

endmodule

// File: pkg/dpt_consts.vh
`ifndef DPT_CONSTS_VH
`define DPT_CONSTS_VH

// fault control register fields
`define DPT_FC_VAL_LSB     0
`define DPT_FC_EN_LSB      4
`define DPT_FC_RESET       8'h00
// write window after the unlock key, in clock cycles
`define DPT_CCP_WINDOW     3'h4

// counter phases
`define DPT_PH_DTA         2'h0
`define DPT_PH_OTA         2'h1
`define DPT_PH_DTB         2'h2
`define DPT_PH_OTB         2'h3

// input modes
`define DPT_IM_NONE        4'h0
`define DPT_IM_JUMP_OPP    4'h1
`define DPT_IM_EXEC_OPP    4'h2
`define DPT_IM_EXEC_OPP_F  4'h3
`define DPT_IM_ALL_FREQ    4'h4
`define DPT_IM_ALL_DEAD    4'h5
`define DPT_IM_ALL_JUMP    4'h6
`define DPT_IM_ALL_SW      4'h7
`define DPT_IM_EDGE_JUMP   4'h8
`define DPT_IM_EDGE_FREQ   4'h9
`define DPT_IM_LVL_FREQ    4'hA

// delay unit modes
`define DPT_DM_OFF         2'h0
`define DPT_DM_BLANK       2'h1
`define DPT_DM_EVENT       2'h2

// delay trigger sources
`define DPT_TS_BCLR        3'h0
`define DPT_TS_ASET        3'h1
`define DPT_TS_BSET        3'h2
`define DPT_TS_ACLR        3'h3
`define DPT_TS_IN_A        3'h4
`define DPT_TS_IN_B        3'h5

`endif
